/* File: include/ccg_regs.svh */
// Constants for the processor clock generator.
// Assumes inclusion by the design file only.
`ifndef CCG_REGS_SVH
`define CCG_REGS_SVH
// Divide ratio of the processor clock
`define CCG_CPU_DIV 2'h3
// Last count of the divide-by-three counter
`define CCG_CPU_LAST 2'h2
// Count value at which the processor clock is high
`define CCG_CPU_HIGH 2'h0
// Reset value of the divide counter
`define CCG_CNT_RST 2'h0
// Counter step per source edge
`define CCG_CNT_STEP 2'h1
// Reset value of both input synchroniser stages
`define CCG_SYNC_RST 7'h00
// Reset level of the generated clocks
`define CCG_CLK_RST 1'h0
// Reset level of the processor reset output, asserted
`define CCG_RESET_RST 1'h1
// Reset level of the ready output
`define CCG_READY_RST 1'h0
`endif

/* File: include/ccg_pkg.sv */
// Types for the processor clock generator.
// Assumes the constants header is on the include path.
package ccg_pkg;
    // Inputs sampled from outside the clock domain
    typedef struct packed {
        logic ext_reset_request_n;
        logic bus_ready;
        logic src_sel;
        logic divider_sync_in;
        logic ready_sync_depth_sel;
    } ccg_pins_s;
    // Generated clock levels and synchronised outputs
    typedef struct packed {
        logic cpu_clk;
        logic periph_clk;
        logic cpu_reset;
        logic cpu_ready;
    } ccg_out_s;
endpackage : ccg_pkg

/* File: hdl/ccg_core.sv */
// Processor clock generator: source select, divide by three, divide by two,
// reset and ready synchronisers. Assumes both oscillator sources arrive as
// pin levels sampled on ref_clk, which runs well above them.
// Overview of operation
// - Processor clock is source divided by three
// - Peripheral clock is processor clock halved
// - Reset output changes on processor clock only
// - Bus ready resynchronised to processor clock
// - Select chooses crystal or external source
// - Sync input keeps several dividers in step
// - Select low crystal, high external input
// - Sync high holds counter; low counts
// - Depth select low two stages, high one
// - Processor clock high one third period
`timescale 1ns/1ns
`include "ccg_regs.svh"
module ccg_core (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic xtal_osc_in,
    input wire logic external_freq_in,
    input wire ccg_pkg::ccg_pins_s pins,
    output ccg_pkg::ccg_out_s outs
);
    import ccg_pkg::*;

    // Width of the input synchroniser, one bit per sampled pin
    localparam int SYNC_W = 7;

    // Input synchronisers, first and second stage
    logic [SYNC_W-1:0] meta_q, meta_d;
    logic [SYNC_W-1:0] sync_q, sync_d;
    // Previous selected source level for edge detect
    logic src_prev_q, src_prev_d;
    // Divide-by-three counter
    logic [1:0] cnt_q, cnt_d;
    // Processor clock level
    logic cpu_clk_q, cpu_clk_d;
    // Peripheral clock, toggled at each processor clock rise
    logic pclk_q, pclk_d;
    // Processor reset output, active high
    logic reset_q, reset_d;
    // First ready stage, sampled at each processor clock rise
    logic rdy1_q, rdy1_d;
    // Ready output to the processor
    logic ready_q, ready_d;
    // Synchronised crystal and external source levels
    logic s_xtal, s_ext_freq;
    // Synchronised reset request, active low
    logic s_reset_req_n;
    // Synchronised bus ready
    logic s_rdy;
    // Synchronised source select
    logic s_sel;
    // Synchronised divider hold
    logic s_div_sync;
    // Synchronised ready depth select
    logic s_depth;
    // Selected source level and its rising edge
    logic src_lvl, src_edge;
    // One-cycle pulse: the counter wraps and the processor clock rises
    logic cpu_rise;

    // True when the counter stands on its last count before wrapping
    function automatic logic ccg_at_last(input logic [1:0] cnt);
        return cnt == `CCG_CPU_LAST;
    endfunction : ccg_at_last

    // Synchroniser stage inputs: pins into the first stage, first into second
    always_comb begin
        meta_d = {xtal_osc_in, external_freq_in, pins.ext_reset_request_n, pins.bus_ready,
                  pins.src_sel, pins.divider_sync_in, pins.ready_sync_depth_sel};
        // Only the second stage reads the first, so metastability stays contained
        sync_d = meta_q;
    end

    // Synchroniser registers; every bit cleared low in reset, reset request included
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= `CCG_SYNC_RST;
            sync_q <= `CCG_SYNC_RST;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    // Split the second stage into named levels
    assign {s_xtal, s_ext_freq, s_reset_req_n, s_rdy, s_sel, s_div_sync, s_depth} = sync_q;

    assign src_lvl = s_sel ? s_ext_freq : s_xtal;
    // Rising edge of the selected source, one cycle wide
    assign src_edge = src_lvl & ~src_prev_q;
    // wrap pulse
    // Counter at its last count takes a source edge while not held
    assign cpu_rise = src_edge && ccg_at_last(cnt_q) && !s_div_sync;

    // Next-state logic for dividers and synchronised outputs
    always_comb begin
        src_prev_d = src_lvl;
        cnt_d = cnt_q;
        cpu_clk_d = cpu_clk_q;
        pclk_d = pclk_q;
        reset_d = reset_q;
        rdy1_d = rdy1_q;
        ready_d = ready_q;
        if (s_div_sync) begin
            // Held at the first count; the clock waits for three fresh edges
            cnt_d = `CCG_CNT_RST;
        end else if (src_edge) begin
            cnt_d = ccg_at_last(cnt_q) ? `CCG_CNT_RST : cnt_q + `CCG_CNT_STEP;
        end
        if (cpu_rise) begin
            // High for the one source period that follows the wrap
            cpu_clk_d = 1'h1;
        end else if (s_div_sync || src_edge) begin
            // The next source edge or a hold ends the high phase
            cpu_clk_d = 1'h0;
        end
        if (cpu_rise) begin
            pclk_d = ~pclk_q;
            reset_d = ~s_reset_req_n;
            rdy1_d = s_rdy;
            // stage depth select
            // One stage takes the pin now, two take the previous rise's sample
            ready_d = s_depth ? s_rdy : rdy1_q;
        end
    end

    // Divider and output registers; outputs come up in their reset levels
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev_q <= 1'h0;
            cnt_q <= `CCG_CNT_RST;
            cpu_clk_q <= `CCG_CLK_RST;
            pclk_q <= `CCG_CLK_RST;
            reset_q <= `CCG_RESET_RST;
            rdy1_q <= `CCG_READY_RST;
            ready_q <= `CCG_READY_RST;
        end else begin
            src_prev_q <= src_prev_d;
            cnt_q <= cnt_d;
            cpu_clk_q <= cpu_clk_d;
            pclk_q <= pclk_d;
            reset_q <= reset_d;
            rdy1_q <= rdy1_d;
            ready_q <= ready_d;
        end
    end

    // Outputs straight from registers
    assign outs = '{cpu_clk: cpu_clk_q, periph_clk: pclk_q, cpu_reset: reset_q,
                    cpu_ready: ready_q};

    // Helper: previous counter for assertions
    logic [1:0] cnt_past_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_past_q <= `CCG_CNT_RST;
        end else begin
            cnt_past_q <= cnt_q;
        end
    end

    // Source edge at the last count while the divider runs
    sequence wrap_s;
        src_edge && !s_div_sync && ccg_at_last(cnt_q);
    endsequence

    cnt_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrap_s |=> cnt_q == `CCG_CNT_RST) else $error("counter did not wrap");
    cnt_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cnt_q < `CCG_CPU_DIV) else $error("counter out of range");
    clk_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrap_s |=> cpu_clk_q) else $error("clock did not rise on wrap");
    rise_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(cpu_clk_q) |-> $past(cpu_rise)) else $error("clock rose without wrap");
    pclk_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(pclk_q) |-> $past(cpu_rise)) else $error("pclk moved off edge");
    pclk_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_rise |=> pclk_q != $past(pclk_q)) else $error("pclk missed a rise");
    reset_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(reset_q) |-> $past(cpu_rise)) else $error("reset moved off edge");
    reset_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_rise |=> reset_q == !$past(s_reset_req_n)) else $error("reset not taken");
    ready_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(ready_q) |-> $past(cpu_rise)) else $error("ready moved off edge");
    rdy_stage_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_rise |=> rdy1_q == $past(s_rdy)) else $error("ready stage not taken");
    src_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_sel |-> src_lvl == s_ext_freq) else $error("wrong source selected");
    src_xtal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !s_sel |-> src_lvl == s_xtal) else $error("crystal not selected");
    hold_cnt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_div_sync |=> cnt_q == `CCG_CNT_RST && !cpu_clk_q) else $error("counter not held");
    depth_two_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_rise && !s_depth |=> ready_q == $past(rdy1_q)) else $error("two-stage ready");
    depth_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_rise && s_depth |=> ready_q == $past(s_rdy)) else $error("one-stage ready");
    duty_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_clk_q |-> cnt_past_q == `CCG_CPU_HIGH || cnt_q == `CCG_CPU_HIGH)
        else $error("clock high outside first third");
    high_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_clk_q |-> cnt_q == `CCG_CPU_HIGH) else $error("clock high off count");
    clk_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_clk_q && src_edge |=> !cpu_clk_q) else $error("high phase too long");
endmodule : ccg_core

/* File: sim/ccg_cpu_model.sv */
// Processor side model: counts rises of both generated clocks.
// Assumes it only watches the block outputs.
`timescale 1ns/1ns
module ccg_cpu_model (
    input wire logic ref_clk,
    input wire ccg_pkg::ccg_out_s outs,
    output int cpu_rises,
    output int per_rises
);
    import ccg_pkg::*;
    logic cpu_q; // Last seen processor clock
    logic per_q; // Last seen peripheral clock
    always_ff @(posedge ref_clk) begin
        cpu_q <= outs.cpu_clk;
        per_q <= outs.periph_clk;
        cpu_rises <= cpu_rises + int'(outs.cpu_clk && !cpu_q);
        per_rises <= per_rises + int'(outs.periph_clk && !per_q);
    end
endmodule : ccg_cpu_model

/* File: sim/ccg_tb_top.sv */
// Bench for the clock generator: periods, duty, sources, sync, reset, ready.
// Assumes the package and the design are compiled first.
`timescale 1ns/1ns
module cpu_clock_divider_reset_sync_tb_top;
    import ccg_pkg::*;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic xo = 1'h0; // Crystal level, period 8 cycles
    logic ef = 1'h0; // External source level, period 12 cycles
    ccg_pins_s pins = 5'h10;
    ccg_out_s outs;
    logic [15:0] t;
    int mismatches = 0, check_count = 0, cr, pr, n = 0;
    always #20 ref_clk = ~ref_clk;
    // Both sources run all the time
    always @(negedge ref_clk) begin
        n <= n + 1;
        xo <= (n % 8) < 4;
        ef <= (n % 12) < 6;
    end
    ccg_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .xtal_osc_in(xo),
        .external_freq_in(ef), .pins(pins), .outs(outs));
    ccg_cpu_model cpu (.ref_clk(ref_clk), .outs(outs), .cpu_rises(cr), .per_rises(pr));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    // Waits for the next processor clock rise; c counts cycles taken
    task automatic rise(output logic [15:0] c);
        c = 16'h0;
        while (outs.cpu_clk !== 1'h0 && c < 16'h12c) begin
            @(negedge ref_clk);
            c++;
        end
        while (outs.cpu_clk !== 1'h1 && c < 16'h12c) begin
            @(negedge ref_clk);
            c++;
        end
        if (c >= 16'h12c) begin
            mismatches++;
            stop_test();
        end
    endtask : rise
    // Period, high time and peripheral ratio for one source
    task automatic clk_src(input logic sel, input logic [15:0] per);
        logic [15:0] u;
        int k;
        pins.src_sel = sel;
        repeat (5) rise(t);
        chk("period", t, per);
        u = 16'h0;
        while (outs.cpu_clk === 1'h1 && u < 16'h64) begin
            @(negedge ref_clk);
            u++;
        end
        chk("high time", u, per / 3);
        k = pr;
        repeat (4) rise(t);
        // The partner model counts an edge one cycle after it shows
        @(negedge ref_clk);
        chk("pclk rises", 16'(pr - k), 16'h2);
    endtask : clk_src
    // Held divider makes no rise; first rise takes three source edges after release
    task automatic sync_chk;
        int k;
        pins.divider_sync_in = 1'h1;
        repeat (4) @(negedge ref_clk);
        k = cr;
        repeat (80) @(negedge ref_clk);
        chk("sync hold", 16'(cr - k), 16'h0);
        pins.divider_sync_in = 1'h0;
        rise(t);
        // External source of 12 cycles: 3 cycles of sync delay, then 2 to 3 periods
        chk("sync run", 16'(t >= 16'h1b && t <= 16'h26), 16'h1);
    endtask : sync_chk
    // Reset follows request; ready depth one or two stages
    task automatic rst_rdy;
        pins.ext_reset_request_n = 1'h0;
        rise(t);
        chk("cpu reset", outs.cpu_reset, 16'h1);
        pins.ext_reset_request_n = 1'h1;
        rise(t);
        chk("cpu reset", outs.cpu_reset, 16'h0);
        for (int d = 0; d < 2; d++) begin
            pins.ready_sync_depth_sel = d[0];
            pins.bus_ready = 1'h0;
            repeat (2) rise(t);
            pins.bus_ready = 1'h1;
            rise(t);
            chk("ready", outs.cpu_ready, 16'(d));
            rise(t);
            chk("ready", outs.cpu_ready, 16'h1);
        end
    endtask : rst_rdy
    // Reset held 8 cycles: outputs in their reset levels, then release
    task automatic reset_chk;
        repeat (8) @(negedge ref_clk);
        chk("in reset", outs, 16'h2);
        rst_n = 1'h1;
    endtask : reset_chk
    initial begin
        reset_chk();
        clk_src(1'h0, 16'h18);
        clk_src(1'h1, 16'h24);
        sync_chk();
        rst_rdy();
        stop_test();
    end
endmodule : cpu_clock_divider_reset_sync_tb_top
